//--- adc_control_sequencer.v
// converter control sequencer with axi4-lite register access
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "adc_control_sequencer_defines.vh"
module adc_control_sequencer (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire conv_done,
    output reg conv_reset_ff,
    output reg conv_start_ff,
    output wire conv_clock_tick,
    output reg converter_power_down_ff,
    output reg bandgap_output_enable_ff,
    output reg reference_source_select_ff,
    output reg [3:0] analog_pin_enables_ff,
    output reg [4:0] input_source_onehot_ff,
    output reg irq_request_ff
);
    localparam ST_IDLE = 2'd0;
    localparam ST_HELD = 2'd1;
    localparam ST_CONVERT = 2'd2;
    reg [1:0] state_ff;
    reg start_bit_ff, busy_ff, data_format_ff, internal_ref_channel_select_ff;
    reg [1:0] channel_select_low_ff;
    reg [2:0] conv_clock_divider_select_ff;
    reg irq_flag_ff, irq_enable_ff, aw_got_ff, w_got_ff, w_lane0_ff;
    reg [7:0] aw_addr_ff, w_data_ff, rd_byte;
    reg done_s1_ff, done_s2_ff, done_s3_ff, done_lvl_ff;
    reg rd_hit;
    wire wr_fire, wr_en, done_rise;
    wire [7:0] ctrl_first_rd, ctrl_second_rd, irq_status_rd;
    // -----------------------------------------------------------------
    // conversion clock divider
    // -----------------------------------------------------------------
    conv_clock_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .div_sel(conv_clock_divider_select_ff),
        .tick_ff(conv_clock_tick)
    );
    // -----------------------------------------------------------------
    // end-of-conversion input from the analog core
    // -----------------------------------------------------------------
    // three stages; the level is only believed once stages two and three agree
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
            done_s3_ff <= 1'b0;
            done_lvl_ff <= 1'b0;
        end
        else
        begin
            done_s1_ff <= conv_done;
            done_s2_ff <= done_s1_ff;
            done_s3_ff <= done_s2_ff;
            if (done_s2_ff == done_s3_ff)
                done_lvl_ff <= done_s3_ff;
        end
    end
    assign done_rise = done_s2_ff & done_s3_ff & ~done_lvl_ff;
    // -----------------------------------------------------------------
    // axi4-lite write channels
    // -----------------------------------------------------------------
    // address and data are taken in either order; response follows both
    assign wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
    assign wr_en = wr_fire & w_lane0_ff;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            w_lane0_ff <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_ff <= s_axi_awaddr;
                aw_got_ff <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_ff <= s_axi_wdata[7:0];
                w_lane0_ff <= s_axi_wstrb[0];
                w_got_ff <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case ({aw_addr_ff[7:2], 2'b00})
                    `OFF_CTRL_FIRST, `OFF_CTRL_SECOND, `OFF_PIN_ENABLE, `OFF_IRQ_STATUS:
                        s_axi_bresp <= `RESP_OKAY;
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    // only writable bits are stored, so unimplemented bits stay zero
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_bit_ff <= `TRIGGER_RST;
            converter_power_down_ff <= 1'b1;
            data_format_ff <= 1'b0;
            channel_select_low_ff <= 2'b00;
            internal_ref_channel_select_ff <= 1'b0;
            bandgap_output_enable_ff <= 1'b0;
            reference_source_select_ff <= 1'b0;
            conv_clock_divider_select_ff <= `DIV_SELECT_RST;
            analog_pin_enables_ff <= `PIN_FIELD_RST;
            irq_enable_ff <= 1'b0;
        end
        else if (wr_en)
        begin
            case ({aw_addr_ff[7:2], 2'b00})
                `OFF_CTRL_FIRST:
                begin
                    start_bit_ff <= w_data_ff[`BIT_START];
                    converter_power_down_ff <= w_data_ff[`BIT_POWER_DOWN];
                    data_format_ff <= w_data_ff[`BIT_DATA_FORMAT];
                    channel_select_low_ff <= w_data_ff[1:0];
                end
                `OFF_CTRL_SECOND:
                begin
                    internal_ref_channel_select_ff <= w_data_ff[`BIT_REF_CH_SEL];
                    bandgap_output_enable_ff <= w_data_ff[`BIT_BANDGAP_EN];
                    reference_source_select_ff <= w_data_ff[`BIT_REF_SRC_SEL];
                    conv_clock_divider_select_ff <= w_data_ff[2:0];
                end
                `OFF_PIN_ENABLE:
                    analog_pin_enables_ff <= w_data_ff[3:0];
                `OFF_IRQ_STATUS:
                    irq_enable_ff <= w_data_ff[`BIT_IRQ_ENABLE];
                default: irq_enable_ff <= irq_enable_ff;
            endcase
        end
    end
    // -----------------------------------------------------------------
    // conversion sequence
    // -----------------------------------------------------------------
    // raising the trigger aborts any conversion in flight; lowering it launches one
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b1;
            conv_reset_ff <= 1'b0;
            conv_start_ff <= 1'b0;
        end
        else
        begin
            conv_start_ff <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    if (start_bit_ff)
                    begin
                        state_ff <= ST_HELD;
                        busy_ff <= 1'b1;
                        conv_reset_ff <= 1'b1;
                    end
                end
                ST_HELD:
                begin
                    if (!start_bit_ff)
                    begin
                        state_ff <= ST_CONVERT;
                        conv_reset_ff <= 1'b0;
                        conv_start_ff <= 1'b1;
                    end
                end
                ST_CONVERT:
                begin
                    if (start_bit_ff)
                    begin
                        state_ff <= ST_HELD;
                        conv_reset_ff <= 1'b1;
                    end
                    else if (done_rise)
                    begin
                        state_ff <= ST_IDLE;
                        busy_ff <= 1'b0;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
    // -----------------------------------------------------------------
    // interrupt request flag and input routing
    // -----------------------------------------------------------------
    // a completion in the same cycle as a write-one clear keeps the flag set
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_flag_ff <= 1'b0;
            irq_request_ff <= 1'b0;
            input_source_onehot_ff <= 5'h00;
        end
        else
        begin
            if (state_ff == ST_CONVERT && !start_bit_ff && done_rise)
                irq_flag_ff <= 1'b1;
            else if (wr_en && {aw_addr_ff[7:2], 2'b00} == `OFF_IRQ_STATUS &&
                     w_data_ff[`BIT_IRQ_FLAG])
                irq_flag_ff <= 1'b0;
            irq_request_ff <= irq_enable_ff &
                (irq_flag_ff | (state_ff == ST_CONVERT && !start_bit_ff && done_rise));
            input_source_onehot_ff <= internal_ref_channel_select_ff ? 5'h10 :
                                      5'h01 << channel_select_low_ff;
        end
    end
    // -----------------------------------------------------------------
    // axi4-lite read channel
    // -----------------------------------------------------------------
    assign ctrl_first_rd = {start_bit_ff, busy_ff, converter_power_down_ff, data_format_ff,
                            2'b00, channel_select_low_ff};
    assign ctrl_second_rd = {internal_ref_channel_select_ff, bandgap_output_enable_ff, 1'b0,
                             reference_source_select_ff, 1'b0, conv_clock_divider_select_ff};
    // the internal reference is only valid with the bandgap running
    assign irq_status_rd = {5'h00, internal_ref_channel_select_ff & ~bandgap_output_enable_ff,
                            irq_enable_ff, irq_flag_ff};
    // read decode; unmapped addresses answer slverr with zero data
    always @*
    begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case ({s_axi_araddr[7:2], 2'b00})
            `OFF_CTRL_FIRST: rd_byte = ctrl_first_rd;
            `OFF_CTRL_SECOND: rd_byte = ctrl_second_rd;
            `OFF_PIN_ENABLE: rd_byte = {4'h0, analog_pin_enables_ff};
            `OFF_IRQ_STATUS: rd_byte = irq_status_rd;
            default: rd_hit = 1'b0;
        endcase
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

//--- adc_control_sequencer_defines.vh
// register map, field positions and reset values of the converter control sequencer
// Function
// - one trigger bit launches and resets converter
// - trigger written 0-1-0 starts one conversion
// - trigger high holds reset and busy flag
// - busy flag cleared when conversion finishes
// - interrupt request flag set every conversion end
// - enabled interrupt raises internal request on completion
// - three-bit divider selects sysclk down to /64
// - pin enable bits turn port pins analog
// - exactly one source routed to converter input
// - low select picks analog input 0..3
// - reference select takes external pin, frees others
// - power-down bit switches converter off when 1
`ifndef ADC_CONTROL_SEQUENCER_DEFINES_VH
`define ADC_CONTROL_SEQUENCER_DEFINES_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define OFF_CTRL_FIRST 8'h00
`define OFF_CTRL_SECOND 8'h04
`define OFF_PIN_ENABLE 8'h08
`define OFF_IRQ_STATUS 8'h0C

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define BIT_START 7
`define BIT_BUSY 6
`define BIT_POWER_DOWN 5
`define BIT_DATA_FORMAT 4
`define BIT_REF_CH_SEL 7
`define BIT_BANDGAP_EN 6
`define BIT_REF_SRC_SEL 4
`define BIT_IRQ_FLAG 0
`define BIT_IRQ_ENABLE 1
`define BIT_REF_INVALID 2

// -----------------------------------------------------------------
// reset values and writable masks
// -----------------------------------------------------------------
`define CTRL_FIRST_RST 8'h60
`define CTRL_FIRST_WMASK 8'hB3
`define CTRL_SECOND_RST 8'h00
`define CTRL_SECOND_WMASK 8'hD7
`define PIN_ENABLE_RST 8'h0F
`define PIN_ENABLE_WMASK 8'h0F
`define TRIGGER_RST 1'h0
`define DIV_SELECT_RST 3'h0
`define PIN_FIELD_RST 4'hF
`define DIV_UNDEFINED 3'b111
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- adc_control_sequencer_properties.sv
// port assertions for the converter control sequencer
`timescale 1ns/1ps
module adc_control_sequencer_properties (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire conv_reset_ff,
    input wire conv_start_ff,
    input wire converter_power_down_ff,
    input wire [3:0] analog_pin_enables_ff,
    input wire [4:0] input_source_onehot_ff
);
    // ----------------------------------------
    // bus handshake and conversion sequencing
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // address and data taken together
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // ready drops, response follows one cycle later
    sequence write_answer;
        !s_axi_awready ##1 s_axi_bvalid;
    endsequence
    a_write_answer: assert property (both_taken |=> write_answer)
        else $error("write response not on time");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response not on time");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_onehot_source: assert property ($past(aresetn) |-> $onehot(input_source_onehot_ff))
        else $error("converter input not one source");
    a_start_follows_hold: assert property ($fell(conv_reset_ff) |-> conv_start_ff)
        else $error("no start after hold release");
    a_start_single: assert property (conv_start_ff |=> !conv_start_ff)
        else $error("start pulse too long");
    a_hold_no_start: assert property (conv_reset_ff |-> !conv_start_ff)
        else $error("start while held");
    // first edge out of reset still shows reset values
    a_reset_values: assert property ($rose(aresetn) |-> converter_power_down_ff && analog_pin_enables_ff == 4'hf)
        else $error("bad output reset values");
endmodule
bind adc_control_sequencer adc_control_sequencer_properties u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .conv_reset_ff(conv_reset_ff), .conv_start_ff(conv_start_ff),
    .converter_power_down_ff(converter_power_down_ff),
    .analog_pin_enables_ff(analog_pin_enables_ff),
    .input_source_onehot_ff(input_source_onehot_ff)
);

//--- adc_control_sequencer_tb_top.sv
// self-checking bench for the converter control sequencer
`timescale 1ns/1ps
module adc_control_sequencer_tb_top;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rd_data;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire conv_done, conv_reset_ff, conv_start_ff, conv_clock_tick;
    wire converter_power_down_ff, bandgap_output_enable_ff;
    wire reference_source_select_ff, irq_request_ff;
    wire [3:0] analog_pin_enables_ff;
    wire [4:0] input_source_onehot_ff;
    int errors, checks_done;
    adc_control_sequencer dut (.*);
    adc_core_model core (.aclk(aclk), .hold(conv_reset_ff), .start(conv_start_ff),
        .tick(conv_clock_tick), .done(conv_done));
    // ----------------------------------------
    // reporting and bus tasks
    // ----------------------------------------
    task automatic tally_and_finish;
    begin
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    end
    endtask
    // a hung handshake ends the run at once
    task automatic bail;
    begin
        errors++;
        $display("unexpected handshake: expected 1 seen 0");
        tally_and_finish;
    end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
    begin
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1 && n < 40);
        if (n >= 40)
            bail;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    end
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1 && n < 40);
        if (n >= 40)
            bail;
        rd_data = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
    begin
        rd(8'h00);
        chk("first reset", 8'h60, rd_data);
        rd(8'h08);
        chk("pins reset", 8'h0f, rd_data);
        wr(8'h04, 8'hff);
        rd(8'h04);
        chk("second mask", 8'hd7, rd_data);
        chk("ref pin", 1'b1, reference_source_select_ff);
        chk("bandgap", 1'b1, bandgap_output_enable_ff);
        wr(8'h08, 8'hf5);
        rd(8'h08);
        chk("pin mask", 8'h05, rd_data);
        chk("pin outputs", 4'h5, analog_pin_enables_ff);
        wr(8'h10, 8'h55);
        chk("bad write", 2'b10, resp);
        rd(8'h10);
        chk("bad read", 2'b10, resp);
    end
    endtask
    // count ticks over a whole number of periods, phase then cannot matter
    task automatic t_dividers;
        int n, k;
    begin
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h04, c[7:0]);
            n = 0;
            while (c < 7 && conv_clock_tick !== 1'b1 && n < 80)
            begin
                @(posedge aclk);
                n++;
            end
            k = 0;
            repeat (128)
            begin
                @(posedge aclk);
                k += conv_clock_tick;
            end
            // code 111 is undefined and gives no conversion clock at all
            chk("ticks", (c < 7) ? (128 >> c) : 0, k);
        end
    end
    endtask
    task automatic t_sources;
    begin
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h00, c[7:0]);
            rd(8'h00);
            chk("source", 1 << c, input_source_onehot_ff);
        end
        chk("power on", 1'b0, converter_power_down_ff);
        wr(8'h04, 8'h80);
        rd(8'h0c);
        chk("ref invalid", 1'b1, rd_data[2]);
        chk("source ref", 5'h10, input_source_onehot_ff);
        wr(8'h04, 8'hc0);
        rd(8'h0c);
        chk("ref valid", 1'b0, rd_data[2]);
    end
    endtask
    task automatic t_convert(input logic en);
        int n;
    begin
        wr(8'h0c, {6'h00, en, 1'b1});
        // slowest divider, the nearest this fast system clock gets to the accurate period range
        wr(8'h04, 8'h06);
        wr(8'h00, 8'h80);
        rd(8'h00);
        chk("held", 1'b1, conv_reset_ff);
        chk("busy held", 1'b1, rd_data[6]);
        wr(8'h00, 8'h00);
        n = 0;
        do
        begin
            rd(8'h00);
            n++;
        end
        while (rd_data[6] !== 1'b0 && n < 200);
        chk("busy end", 1'b0, rd_data[6]);
        chk("irq line", en, irq_request_ff);
        rd(8'h0c);
        chk("irq flag", 1'b1, rd_data[0]);
        wr(8'h0c, 8'h01);
        rd(8'h0c);
        chk("flag clear", 1'b0, rd_data[0]);
        chk("irq cleared", 1'b0, irq_request_ff);
    end
    endtask
    // clock and main sequence
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_dividers;
        t_sources;
        t_convert(1'b1);
        t_convert(1'b0);
        tally_and_finish;
    end
endmodule

//--- adc_core_model.sv
// behavioural analog converter core answering start pulses
`timescale 1ns/1ps
module adc_core_model #(
    parameter integer CONV_TICKS = 4
) (
    input wire aclk,
    input wire hold,
    input wire start,
    input wire tick,
    output reg done
);
    integer left_ff = 0;
    initial done = 1'b0;
    // done only after whole tick count, so slow dividers answer slowly
    always @(posedge aclk)
    begin
        if (hold)
        begin
            done <= 1'b0;
            left_ff <= 0;
        end
        else if (start)
        begin
            done <= 1'b0;
            left_ff <= CONV_TICKS;
        end
        else if (left_ff != 0 && tick)
        begin
            left_ff <= left_ff - 1;
            done <= (left_ff == 1);
        end
    end
endmodule

//--- conv_clock_divider.v
// conversion clock tick generator dividing the system clock by 1..64
`timescale 1ns/1ps
`include "adc_control_sequencer_defines.vh"
module conv_clock_divider (
    input wire aclk,
    input wire aresetn,
    input wire [2:0] div_sel,
    output reg tick_ff
);
    reg [5:0] cnt_ff;
    reg [5:0] mask;

    // -----------------------------------------------------------------
    // divide mask per select code
    // -----------------------------------------------------------------
    always @*
    begin
        case (div_sel)
            3'b000: mask = 6'h00;
            3'b001: mask = 6'h01;
            3'b010: mask = 6'h03;
            3'b011: mask = 6'h07;
            3'b100: mask = 6'h0F;
            3'b101: mask = 6'h1F;
            3'b110: mask = 6'h3F;
            default: mask = 6'h3F;
        endcase
    end

    // one tick per conversion clock period; undefined code gives no clock
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_ff <= 6'h00;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= cnt_ff + 6'h01;
            tick_ff <= (div_sel != `DIV_UNDEFINED) && ((cnt_ff & mask) == mask);
        end
    end
endmodule
